// *** rtl/ppas_pkg.sv ***
// package for the parallel port address and status block
// assumes an ahb-lite register slave with 32-bit words, one register per word
package ppas_pkg;
  // -----------------------------------------
  // register byte addresses
  // -----------------------------------------
  localparam logic [7:0] PPAS_ADDR_OFS = 8'h00;
  localparam logic [7:0] PPAS_PADEN_OFS = 8'h04;
  localparam logic [7:0] PPAS_STAT_OFS = 8'h08;
  localparam logic [7:0] PPAS_PADCFG_OFS = 8'h0C;
  localparam logic [7:0] PPAS_CTRL_OFS = 8'h10;
  localparam logic [7:0] PPAS_IBUF_OFS = 8'h14;
  localparam logic [7:0] PPAS_OUTPUT_UNDERFLOW_FLAG_OFS = 8'h24;
  // -----------------------------------------
  // field layout and reset values
  // -----------------------------------------
  localparam int PPAS_CS1_BIT = 14;
  localparam int PPAS_TOP_BIT = 15;
  localparam logic [15:0] PPAS_PADEN_MASK = 16'h47FF;
  localparam logic [15:0] PPAS_PADCFG_MASK = 16'h0001;
  localparam logic [15:0] PPAS_ADDR_RST = 16'h0000;
  localparam logic [15:0] PPAS_PADEN_RST = 16'h0000;
  localparam logic [15:0] PPAS_PADCFG_RST = 16'h0000;
  localparam logic [3:0] PPAS_OEMPTY_RST = 4'hF;
  localparam logic [3:0] PPAS_IFULL_RST = 4'h0;
  localparam int PPAS_STAT_IBF = 15;
  localparam int PPAS_STAT_INPUT_OVERFLOW_FLAG = 14;
  localparam int PPAS_STAT_OBE = 7;
  localparam int PPAS_STAT_OUTPUT_UNDERFLOW_FLAG = 6;
  // control register: mode 1:0, step 3:2, cs1 polarity 4
  localparam int PPAS_CTRL_MODE_LSB = 0;
  localparam int PPAS_CTRL_STEP_LSB = 2;
  localparam int PPAS_CTRL_CSP_BIT = 4;
  localparam logic [4:0] PPAS_CTRL_RST = 5'h00;
  // -----------------------------------------
  // enumerations
  // -----------------------------------------
  typedef enum logic [1:0]
  {
    PPAS_MODE_LEGACY = 2'b00,
    PPAS_MODE_ENH_SLAVE = 2'b01,
    PPAS_MODE_MASTER_SEP = 2'b10,
    PPAS_MODE_MASTER_ENB = 2'b11
  } ppas_mode_t;
  typedef enum logic [1:0]
  {
    PPAS_STEP_HOLD = 2'b00,
    PPAS_STEP_INC = 2'b01,
    PPAS_STEP_DEC = 2'b10,
    PPAS_STEP_BUFINC = 2'b11
  } ppas_step_t;
endpackage : ppas_pkg

// *** rtl/ppas_slots.sv ***
// four byte-wide slots with full/empty flags and sticky error flags
// assumes one software access and one link access per cycle at most
`timescale 1ns/10ps
module ppas_slots
  import ppas_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_link_wr,
  input wire logic [1:0] i_link_wr_idx,
  input wire logic [7:0] i_link_wdata,
  input wire logic i_link_rd,
  input wire logic [1:0] i_link_rd_idx,
  input wire logic i_sw_ird,
  input wire logic [1:0] i_sw_ird_idx,
  input wire logic i_sw_owr,
  input wire logic [1:0] i_sw_owr_idx,
  input wire logic [7:0] i_sw_wdata,
  input wire logic i_sw_err_wr,
  input wire logic i_sw_input_overflow_flag_val,
  input wire logic i_sw_output_underflow_flag_val,
  output logic [3:0] o_ifull,
  output logic [3:0] o_oempty,
  output logic o_input_overflow_flag,
  output logic o_output_underflow_flag,
  output logic [31:0] o_ibytes,
  output logic [31:0] o_obytes
);
  logic [7:0] ibuf_reg [4];
  logic [7:0] output_underflow_flag_reg [4];
  genvar g;
  // -----------------------------------------
  // per slot state
  // -----------------------------------------
  generate
    for (g = 0; g < 4; g++)
    begin : g_slot
      always_ff @(posedge i_clk)
      begin
        if (!i_nrst)
        begin
          o_ifull[g] <= PPAS_IFULL_RST[g];
          ibuf_reg[g] <= 8'h00;
        end
        else if (i_link_wr && i_link_wr_idx == g && !o_ifull[g])
        begin
          // data arrival wins over a same-cycle software read
          o_ifull[g] <= 1'b1; // see R8
          ibuf_reg[g] <= i_link_wdata;
        end
        else if (i_sw_ird && i_sw_ird_idx == g)
        begin
          o_ifull[g] <= 1'b0; // see R8
        end
      end
      always_ff @(posedge i_clk)
      begin
        if (!i_nrst)
        begin
          o_oempty[g] <= PPAS_OEMPTY_RST[g];
          output_underflow_flag_reg[g] <= 8'h00;
        end
        else if (i_sw_owr && i_sw_owr_idx == g)
        begin
          o_oempty[g] <= 1'b0; // see R11
          output_underflow_flag_reg[g] <= i_sw_wdata;
        end
        else if (i_link_rd && i_link_rd_idx == g)
        begin
          o_oempty[g] <= 1'b1; // see R11
        end
      end
      assign o_ibytes[8*g +: 8] = ibuf_reg[g];
      assign o_obytes[8*g +: 8] = output_underflow_flag_reg[g];
    end
  endgenerate
  // -----------------------------------------
  // sticky errors: hardware set beats software clear
  // -----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_input_overflow_flag <= 1'b0;
    else if (i_link_wr && o_ifull[i_link_wr_idx])
      o_input_overflow_flag <= 1'b1; // see R7, R16
    else if (i_sw_err_wr)
      o_input_overflow_flag <= o_input_overflow_flag & i_sw_input_overflow_flag_val; // see R16
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_output_underflow_flag <= 1'b0;
    else if (i_link_rd && o_oempty[i_link_rd_idx])
      o_output_underflow_flag <= 1'b1; // see R10, R16
    else if (i_sw_err_wr)
      o_output_underflow_flag <= o_output_underflow_flag & i_sw_output_underflow_flag_val; // see R16
  end
endmodule : ppas_slots

// *** rtl/ppas_top.sv ***
// register part of a parallel port unit: target address, pad ownership,
// slave buffer status and pad input type, behind an ahb-lite slave
// assumes a single-master ahb-lite bus and a link partner that accesses
// one slot per cycle with synchronous strobes
// -----------------------------------------
// Notes on behaviour
// R1 - bit 14 of the target address drives chip select one, through the polarity bit.
// R2 - the target address holds a 14-bit low field and a top bit 15 shown on the address pins.
// R3 - pad enable bit 14 hands pad 14 to the port, else it stays general i/o.
// R4 - pad enable bits 10 to 2 hand those pads to the port as address outputs.
// R5 - pad enable bits 1 and 0 hand the low pads to the port as address or latch strobes.
// R6 - the input all full flag reads one only when every input slot holds data.
// R7 - a link write to a full input slot sets a sticky overflow flag.
// R8 - each input slot flag sets on arrival and clears when software reads the slot.
// R9 - the output empty flag reads one when all output slots are empty, one after reset.
// R10 - a link read from an empty output slot sets a sticky underflow flag.
// R11 - each output slot flag clears on a software write and sets again when the link reads it.
// R12 - a pad config bit selects ttl inputs when set, schmitt inputs when clear.
// R13 - a two-bit mode field picks legacy slave, enhanced slave or one of two master modes.
// R14 - a two-bit step field holds, increments, decrements or steps legacy slots per cycle.
// R15 - unimplemented bits ignore writes and read as zero.
// R16 - hardware flags update on the clock edge after the link access; writing zero clears errors.
// -----------------------------------------
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module ppas_top
  import ppas_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_link_wr,
  input wire logic i_link_rd,
  input wire logic [1:0] i_link_idx,
  input wire logic [7:0] i_link_wdata,
  input wire logic i_cycle_done,
  output logic [7:0] o_link_rdata,
  output logic [15:0] o_port_address_pins,
  output logic [15:0] o_pad_port_owned,
  output logic o_chip_select_one_pin,
  output logic o_ttl_input_select,
  output logic [1:0] o_mode,
  output logic o_master_mode
);
  logic [15:0] addr_reg;
  logic [15:0] paden_reg;
  logic [15:0] padcfg_reg;
  logic [4:0] ctrl_reg;
  logic [1:0] slot_ptr_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [3:0] ifull;
  logic [3:0] oempty;
  logic input_overflow_flag;
  logic output_underflow_flag;
  logic [31:0] ibytes;
  logic [31:0] obytes;
  logic [15:0] stat_word;
  logic [15:0] addr_next;
  logic addr_phase;
  logic rd_take;
  logic [1:0] link_slot;
  logic sw_ird;
  logic sw_owr;
  logic sw_err_wr;
  ppas_mode_t mode;
  ppas_step_t step;
  // -----------------------------------------
  // decode helpers
  // -----------------------------------------
  function automatic logic in_slot_range(input logic [7:0] a, input logic [7:0] base);
    in_slot_range = (a >= base) && (a < base + 8'h10) && (a[1:0] == 2'b00);
  endfunction : in_slot_range
  function automatic logic [1:0] slot_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    slot_of = d[3:2];
  endfunction : slot_of
  assign mode = ppas_mode_t'(ctrl_reg[PPAS_CTRL_MODE_LSB +: 2]);
  assign step = ppas_step_t'(ctrl_reg[PPAS_CTRL_STEP_LSB +: 2]);
  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign rd_take = addr_phase && !i_hwrite;
  // legacy auto-increment walks the slots; other modes use the low address bits
  assign link_slot = (mode == PPAS_MODE_LEGACY && step == PPAS_STEP_BUFINC) ?
    slot_ptr_reg : i_link_idx; // see R14
  assign sw_ird = rd_take && in_slot_range(i_haddr[7:0], PPAS_IBUF_OFS);
  assign sw_owr = wr_pend_reg && in_slot_range(wr_addr_reg, PPAS_OUTPUT_UNDERFLOW_FLAG_OFS);
  assign sw_err_wr = wr_pend_reg && wr_addr_reg == PPAS_STAT_OFS;
  assign stat_word = {&ifull, input_overflow_flag, 2'b00, ifull, &oempty, output_underflow_flag, 2'b00, oempty}; // see R6, R9, R15
  ppas_slots u_slots
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_link_wr(i_link_wr),
    .i_link_wr_idx(link_slot),
    .i_link_wdata(i_link_wdata),
    .i_link_rd(i_link_rd),
    .i_link_rd_idx(link_slot),
    .i_sw_ird(sw_ird),
    .i_sw_ird_idx(slot_of(i_haddr[7:0], PPAS_IBUF_OFS)),
    .i_sw_owr(sw_owr),
    .i_sw_owr_idx(slot_of(wr_addr_reg, PPAS_OUTPUT_UNDERFLOW_FLAG_OFS)),
    .i_sw_wdata(i_hwdata[7:0]),
    .i_sw_err_wr(sw_err_wr),
    .i_sw_input_overflow_flag_val(i_hwdata[PPAS_STAT_INPUT_OVERFLOW_FLAG]),
    .i_sw_output_underflow_flag_val(i_hwdata[PPAS_STAT_OUTPUT_UNDERFLOW_FLAG]),
    .o_ifull(ifull),
    .o_oempty(oempty),
    .o_input_overflow_flag(input_overflow_flag),
    .o_output_underflow_flag(output_underflow_flag),
    .o_ibytes(ibytes),
    .o_obytes(obytes)
  );
  // -----------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // -----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_phase && i_hwrite;
      wr_addr_reg <= i_haddr[7:0];
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end
  // read data registered at the address phase, so it stands in the data phase
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_hrdata <= 32'h00000000;
    else if (rd_take)
    begin
      o_hrdata <= 32'h00000000; // see R15
      case (i_haddr[7:0])
        PPAS_ADDR_OFS: o_hrdata[15:0] <= addr_reg;
        PPAS_PADEN_OFS: o_hrdata[15:0] <= paden_reg;
        PPAS_STAT_OFS: o_hrdata[15:0] <= stat_word;
        PPAS_PADCFG_OFS: o_hrdata[15:0] <= padcfg_reg;
        PPAS_CTRL_OFS: o_hrdata[4:0] <= ctrl_reg;
        default:
        begin
          if (in_slot_range(i_haddr[7:0], PPAS_IBUF_OFS))
            o_hrdata[7:0] <= ibytes[8*slot_of(i_haddr[7:0], PPAS_IBUF_OFS) +: 8];
          else if (in_slot_range(i_haddr[7:0], PPAS_OUTPUT_UNDERFLOW_FLAG_OFS))
            o_hrdata[7:0] <= obytes[8*slot_of(i_haddr[7:0], PPAS_OUTPUT_UNDERFLOW_FLAG_OFS) +: 8];
        end
      endcase
    end
  end
  // -----------------------------------------
  // address register with step logic
  // -----------------------------------------
  always_comb
  begin
    addr_next = addr_reg;
    if (wr_pend_reg && wr_addr_reg == PPAS_ADDR_OFS)
      addr_next = i_hwdata[15:0]; // see R1, R2
    else if (i_cycle_done && step == PPAS_STEP_INC)
      addr_next = {addr_reg[15:14], addr_reg[13:0] + 14'h0001}; // see R14
    else if (i_cycle_done && step == PPAS_STEP_DEC)
      addr_next = {addr_reg[15:14], addr_reg[13:0] - 14'h0001}; // see R14
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      addr_reg <= PPAS_ADDR_RST;
    else
      addr_reg <= addr_next;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      slot_ptr_reg <= 2'b00;
    else if (step == PPAS_STEP_BUFINC && (i_link_wr || i_link_rd))
      slot_ptr_reg <= slot_ptr_reg + 2'b01; // see R14
  end
  // -----------------------------------------
  // pad enables, pad config and control
  // -----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      paden_reg <= PPAS_PADEN_RST;
    else if (wr_pend_reg && wr_addr_reg == PPAS_PADEN_OFS)
      paden_reg <= i_hwdata[15:0] & PPAS_PADEN_MASK; // see R3, R4, R5, R15
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      padcfg_reg <= PPAS_PADCFG_RST;
    else if (wr_pend_reg && wr_addr_reg == PPAS_PADCFG_OFS)
      padcfg_reg <= i_hwdata[15:0] & PPAS_PADCFG_MASK; // see R12, R15
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      ctrl_reg <= PPAS_CTRL_RST;
    else if (wr_pend_reg && wr_addr_reg == PPAS_CTRL_OFS)
      ctrl_reg <= i_hwdata[4:0]; // see R13, R14
  end
  // -----------------------------------------
  // pad outputs, registered from the current register values
  // -----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_port_address_pins <= 16'h0000;
      o_pad_port_owned <= 16'h0000;
      o_chip_select_one_pin <= 1'b0;
      o_ttl_input_select <= 1'b0;
      o_mode <= 2'b00;
      o_master_mode <= 1'b0;
    end
    else
    begin
      // pins one cycle behind the registers
      o_port_address_pins <= addr_reg & {addr_reg[PPAS_TOP_BIT], paden_reg[14:0]}; // see R2, R4
      o_pad_port_owned <= paden_reg; // see R3, R4, R5
      o_chip_select_one_pin <= paden_reg[PPAS_CS1_BIT] &
        (addr_reg[PPAS_CS1_BIT] ~^ ctrl_reg[PPAS_CTRL_CSP_BIT]); // see R1
      o_ttl_input_select <= padcfg_reg[0]; // see R12
      o_mode <= mode; // see R13
      o_master_mode <= mode[1]; // see R13
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_link_rdata <= 8'h00;
    else if (i_link_rd)
      o_link_rdata <= obytes[8*link_slot +: 8];
  end
  // -----------------------------------------
  // checks
  // -----------------------------------------
  ibf_all_full_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R6
    stat_word[PPAS_STAT_IBF] == (ifull == 4'hF))
    else $error("all full flag wrong");
  ovf_sticky_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R7
    (i_link_wr && ifull[link_slot]) |=> input_overflow_flag)
    else $error("overflow not set");
  ifull_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R8
    (sw_ird && !i_link_wr) |=> !ifull[$past(slot_of(i_haddr[7:0], PPAS_IBUF_OFS))])
    else $error("input flag not cleared");
  obe_all_empty_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R9
    stat_word[PPAS_STAT_OBE] == (oempty == 4'hF))
    else $error("output empty flag wrong");
  udf_sticky_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R10
    (i_link_rd && oempty[link_slot]) |=> output_underflow_flag)
    else $error("underflow not set");
  oempty_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R11
    sw_owr |=> !oempty[$past(slot_of(wr_addr_reg, PPAS_OUTPUT_UNDERFLOW_FLAG_OFS))])
    else $error("output flag not cleared");
  cs_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R1
    ##1 o_chip_select_one_pin == $past(paden_reg[14] &
      (addr_reg[14] ~^ ctrl_reg[PPAS_CTRL_CSP_BIT])))
    else $error("chip select wrong");
  ttl_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R12
    $rose(padcfg_reg[0]) |=> o_ttl_input_select)
    else $error("ttl select late");
  addr_inc_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R14
    (i_cycle_done && step == PPAS_STEP_INC && !wr_pend_reg) |=>
      addr_reg[13:0] == $past(addr_reg[13:0]) + 14'h0001)
    else $error("address step wrong");
  unimpl_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R15
    (paden_reg & ~PPAS_PADEN_MASK) == 16'h0000 && padcfg_reg[15:1] == 15'h0000)
    else $error("unimplemented bit set");
  err_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see R16
    (sw_err_wr && !i_hwdata[PPAS_STAT_INPUT_OVERFLOW_FLAG] && !i_link_wr) |=> !input_overflow_flag)
    else $error("overflow not cleared");
endmodule : ppas_top

// *** test/ppas_link_model.sv ***
// link partner model: an external host that writes and reads the byte slots
// assumes strobes are sampled by the block on the rising edge of i_clk
`timescale 1ns/10ps
module ppas_link_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_link_rdata,
  output logic o_link_wr,
  output logic o_link_rd,
  output logic [1:0] o_link_idx,
  output logic [7:0] o_link_wdata,
  output logic o_cycle_done
);
  // -----------------------------------------
  // idle state
  // -----------------------------------------
  // released lines show the inverse of their last value, so a stale byte never matches
  initial
  begin
    o_link_wr = 1'b0;
    o_link_rd = 1'b0;
    o_link_idx = 2'h0;
    o_link_wdata = 8'h00;
    o_cycle_done = 1'b0;
  end
  // -----------------------------------------
  // link accesses
  // -----------------------------------------
  // a write to a full slot is only made when the bench asks for it
  task automatic link_write(input logic [1:0] idx, input logic [7:0] data);
    @(posedge i_clk);
    o_link_wr <= 1'b1;
    o_link_idx <= idx;
    o_link_wdata <= data;
    @(posedge i_clk);
    o_link_wr <= 1'b0;
    o_link_idx <= ~idx;
    o_link_wdata <= ~data;
  endtask : link_write
  // the byte is registered at the taking edge and read just after it
  task automatic link_read(input logic [1:0] idx, output logic [7:0] data);
    @(posedge i_clk);
    o_link_rd <= 1'b1;
    o_link_idx <= idx;
    @(posedge i_clk);
    o_link_rd <= 1'b0;
    o_link_idx <= ~idx;
    #1;
    data = i_link_rdata;
  endtask : link_read
  task automatic cycle_pulse();
    @(posedge i_clk);
    o_cycle_done <= 1'b1;
    @(posedge i_clk);
    o_cycle_done <= 1'b0;
  endtask : cycle_pulse
endmodule : ppas_link_model

// *** test/test_ppas_top.sv ***
// self-checking bench for the parallel port address and status block
// assumes the ahb-lite slave answers with hreadyout and an okay response
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module test_ppas_top;
  import ppas_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0000_0000;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0000_0000;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  logic link_wr, link_rd, cycle_done;
  logic [1:0] link_idx;
  logic [7:0] link_wdata, o_link_rdata, rb;
  logic [15:0] o_port_address_pins, o_pad_port_owned;
  logic o_chip_select_one_pin, o_ttl_input_select, o_master_mode;
  logic [1:0] o_mode;
  logic [31:0] rd;
  int n_fail = 0;
  int check_count = 0;
  always #12.5 i_clk = ~i_clk;
  // -----------------------------------------
  // design and link partner
  // -----------------------------------------
  ppas_top DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_link_wr(link_wr), .i_link_rd(link_rd), .i_link_idx(link_idx),
    .i_link_wdata(link_wdata), .i_cycle_done(cycle_done), .o_link_rdata(o_link_rdata),
    .o_port_address_pins(o_port_address_pins), .o_pad_port_owned(o_pad_port_owned),
    .o_chip_select_one_pin(o_chip_select_one_pin), .o_ttl_input_select(o_ttl_input_select),
    .o_mode(o_mode), .o_master_mode(o_master_mode));
  ppas_link_model u_link (.i_clk(i_clk), .i_link_rdata(o_link_rdata), .o_link_wr(link_wr),
    .o_link_rd(link_rd), .o_link_idx(link_idx), .o_link_wdata(link_wdata),
    .o_cycle_done(cycle_done));
  // -----------------------------------------
  // bus tasks
  // -----------------------------------------
  // one single word transfer; waits on hready instead of assuming the latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    i_haddr <= {24'h000000, a};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= wd;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    d = o_hrdata;
    `CHK(o_hresp, 1'b0)
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, rd);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    `CHK(rd, exp)
  endtask : chk_rd
  // pins lag their register by one clock
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    conclude();
  end
  // -----------------------------------------
  // tests
  // -----------------------------------------
  logic [7:0] step_code [3] = '{8'h08, 8'h04, 8'h00};
  logic [15:0] step_exp [3] = '{16'hFFFF, 16'hC000, 16'hC000};
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    // reset values and unimplemented bits
    chk_rd(PPAS_ADDR_OFS, 32'h0);
    chk_rd(PPAS_PADEN_OFS, 32'h0);
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    chk_rd(PPAS_PADCFG_OFS, 32'h0);
    chk_rd(8'h40, 32'h0);
    wr(PPAS_ADDR_OFS, 32'hFFFF_FFFF);
    chk_rd(PPAS_ADDR_OFS, 32'h0000_FFFF);
    wr(PPAS_PADEN_OFS, 32'hFFFF_FFFF);
    chk_rd(PPAS_PADEN_OFS, 32'h0000_47FF);
    wr(PPAS_PADCFG_OFS, 32'hFFFF_FFFF);
    chk_rd(PPAS_PADCFG_OFS, 32'h0000_0001);
    settle();
    `CHK(o_ttl_input_select, 1'b1)
    wr(PPAS_PADCFG_OFS, 32'h0);
    settle();
    `CHK(o_ttl_input_select, 1'b0)
    wr(PPAS_STAT_OFS, 32'hFFFF_FFFF);
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    // pad ownership and address pins
    wr(PPAS_ADDR_OFS, 32'h0000_4155);
    settle();
    `CHK(o_pad_port_owned, 16'h47FF)
    `CHK(o_port_address_pins[10:0], 11'h155)
    wr(PPAS_PADEN_OFS, 32'h0000_4003);
    settle();
    `CHK(o_port_address_pins[10:0], 11'h001)
    `CHK(o_pad_port_owned, 16'h4003)
    // chip select one against polarity, then with its pad released
    for (int i = 0; i < 4; i++)
    begin
      wr(PPAS_CTRL_OFS, i[1] ? 32'h10 : 32'h0);
      wr(PPAS_ADDR_OFS, i[0] ? 32'h4000 : 32'h0);
      settle();
      `CHK(o_chip_select_one_pin, ~(i[0] ^ i[1]))
    end
    wr(PPAS_PADEN_OFS, 32'h0);
    settle();
    `CHK(o_chip_select_one_pin, 1'b0)
    // every mode code
    for (int m = 0; m < 4; m++)
    begin
      wr(PPAS_CTRL_OFS, m);
      settle();
      `CHK(o_mode, m[1:0])
      `CHK(o_master_mode, m[1])
    end
    // address step codes, wrapping the low field only
    wr(PPAS_ADDR_OFS, 32'hC000);
    for (int s = 0; s < 3; s++)
    begin
      wr(PPAS_CTRL_OFS, {24'h0, step_code[s]});
      u_link.cycle_pulse();
      chk_rd(PPAS_ADDR_OFS, {16'h0, step_exp[s]});
    end
    // pads released, so only the top address bit reaches the pins
    settle();
    `CHK(o_port_address_pins, 16'h8000)
    // legacy slave with slot stepping: index ignored, slots filled in order
    wr(PPAS_CTRL_OFS, 32'h0C);
    for (int k = 0; k < 4; k++)
    begin
      u_link.link_write(2'h3, 8'hA0 + k[7:0]);
    end
    chk_rd(PPAS_STAT_OFS, 32'h0000_8F8F);
    for (int k = 0; k < 4; k++)
    begin
      chk_rd(PPAS_IBUF_OFS + 8'(4 * k), 32'hA0 + k);
    end
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    // enhanced slave: fill, overflow, sticky clear
    wr(PPAS_CTRL_OFS, 32'h01);
    for (int k = 0; k < 3; k++)
    begin
      u_link.link_write(k[1:0], 8'h10 + k[7:0]);
    end
    chk_rd(PPAS_STAT_OFS, 32'h0000_078F);
    u_link.link_write(2'h3, 8'h13);
    chk_rd(PPAS_STAT_OFS, 32'h0000_8F8F);
    u_link.link_write(2'h1, 8'h55);
    chk_rd(PPAS_STAT_OFS, 32'h0000_CF8F);
    chk_rd(PPAS_IBUF_OFS + 8'h04, 32'h11);
    // slot 1 is now empty, so the all full flag drops with it
    chk_rd(PPAS_STAT_OFS, 32'h0000_4D8F);
    wr(PPAS_STAT_OFS, 32'h4000);
    chk_rd(PPAS_STAT_OFS, 32'h0000_4D8F);
    wr(PPAS_STAT_OFS, 32'h0);
    chk_rd(PPAS_STAT_OFS, 32'h0000_0D8F);
    chk_rd(PPAS_IBUF_OFS, 32'h10);
    chk_rd(PPAS_IBUF_OFS + 8'h08, 32'h12);
    chk_rd(PPAS_IBUF_OFS + 8'h0C, 32'h13);
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    // output slot: load, drain, underflow
    wr(PPAS_OUTPUT_UNDERFLOW_FLAG_OFS + 8'h08, 32'hA5);
    chk_rd(PPAS_STAT_OFS, 32'h0000_000B);
    u_link.link_read(2'h2, rb);
    `CHK(rb, 8'hA5)
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    u_link.link_read(2'h2, rb);
    chk_rd(PPAS_STAT_OFS, 32'h0000_00CF);
    wr(PPAS_STAT_OFS, 32'h40);
    chk_rd(PPAS_STAT_OFS, 32'h0000_00CF);
    wr(PPAS_STAT_OFS, 32'h0);
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    // reset in mid-run
    wr(PPAS_ADDR_OFS, 32'h1234);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    chk_rd(PPAS_ADDR_OFS, 32'h0);
    chk_rd(PPAS_STAT_OFS, 32'h0000_008F);
    conclude();
  end
endmodule : test_ppas_top
